/* hdl/sram_defs.svh */
// Constants for the pipelined SRAM core: widths, register map, field positions.
// Included by the package; the design modules use its macros. Definitions only.
`ifndef SRAM_DEFS_SVH
`define SRAM_DEFS_SVH

`define ADDR_W 19
`define DATA_W 32
`define PAR_W 4
`define WB_ADR_W 8

`define REG_CTRL 8'h00
`define REG_STATUS 8'h04
`define REG_ADDR 8'h08

`define CTRL_SLEEP_BIT 0
`define CTRL_RESET 1'b0

`define ST_SLEEP_BIT 0
`define ST_INTERLEAVE_BIT 1
`define ST_OFFSET_LO 2
`define ST_DRIVE_BIT 4
`define ST_SELECTED_BIT 5
`define ST_READ_BIT 6

`endif

/* hdl/sram_pkg.sv */
// Types shared by the SRAM core modules.
// Assumes sram_defs.svh is on the include path.
`include "sram_defs.svh"

package sram_pkg;

  typedef logic [`ADDR_W-1:0] addr_t;
  typedef logic [`DATA_W-1:0] data_t;
  typedef logic [`PAR_W-1:0] par_t;
  typedef logic [`WB_ADR_W-1:0] wb_adr_t;

  typedef enum logic [1:0] {
    CYC_IDLE = 2'b00,
    CYC_READ = 2'b01,
    CYC_WRITE = 2'b10
  } cycle_t;

endpackage

/* hdl/burst_if.sv */
// Signals between the access sequencer and the two-bit burst counter.
// Assumes both ends share one clock.
`timescale 1ns/1ns
`default_nettype none

interface burst_if;
  logic load;
  logic step;
  logic interleave;
  logic [1:0] start;
  logic [1:0] offset;

  modport ctrl (output load, output step, output interleave, output start, input offset);
  modport ctr (input load, input step, input interleave, input start, output offset);
endinterface

`default_nettype wire

/* hdl/burst_counter.sv */
// Two-bit burst counter with linear or interleaved order.
// Assumes load and step are never high together.
`timescale 1ns/1ns
`default_nettype none

module burst_counter
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  burst_if.ctr bus
);
  import sram_pkg::*;

  logic [1:0] start_q;
  logic [1:0] start_d;
  logic [1:0] count_q;
  logic [1:0] count_d;

  always_comb
  begin
    start_d = start_q;
    count_d = count_q;
    if (bus.load)
    begin
      start_d = bus.start;
      count_d = 2'h0;
    end
    else if (bus.step)
    begin
      count_d = count_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      start_q <= 2'h0;
      count_q <= 2'h0;
    end
    else if (ce_i)
    begin
      start_q <= start_d;
      count_q <= count_d;
    end
  end

  // Interleaved order flips start bits; linear adds modulo four
  assign bus.offset = bus.interleave ? (start_q ^ count_q) : (start_q + count_q);

endmodule

`default_nettype wire

/* hdl/pipelined_sram.sv */
// Pipelined burst SRAM core with strobes, sleep, registered data pins and a
// classic Wishbone slave for control and status. Assumes all pins are synchronous to clk_i.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - A low controller strobe seen at a rising edge with the primary select low loads the address inputs into the address register.
// - An accepted controller strobe also loads the two low address bits into the burst counter as start.
// - With both strobes low and the primary select low at one edge only the processor strobe counts and the cycle is a processor access.
// - While sleep is requested the core goes quiet, keeps memory contents and takes no accesses.
// - The far side keeps sleep low for normal work and an undriven sleep input counts as low.
// - Data and parity pins used as inputs are captured into an input register at the rising edge.
// - Read data shows the location whose address was captured at the previous edge of the read.
// - The pins are driven while the output enable is low and released while it is high.
// - The processor strobe is ignored when the primary select is high at that edge.
// - The first clock of a read that follows a deselected state does not drive the pins.
// - A low burst step input during a burst advances the burst counter at the edge.
// - The burst order is linear with the strap low and interleaved with it high or open.
module pipelined_sram
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire sram_pkg::addr_t address_i,
  input wire logic controller_address_strobe_n_i,
  input wire logic processor_address_strobe_n_i,
  input wire logic primary_select_n_i,
  input wire logic burst_step_n_i,
  input wire logic write_n_i,
  input wire logic burst_order_i,
  input wire logic sleep_request_i,
  input wire logic output_enable_n_i,
  input wire sram_pkg::data_t data_i,
  output logic [`DATA_W-1:0] data_o,
  output logic data_oe_o,
  input wire sram_pkg::par_t byte_parity_io_i,
  output logic [`PAR_W-1:0] byte_parity_io_o,
  output logic byte_parity_io_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire sram_pkg::wb_adr_t wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o
);
  import sram_pkg::*;

  localparam int DEPTH = 1 << `ADDR_W;

  logic [`DATA_W+`PAR_W-1:0] mem [DEPTH];

  burst_if burst ();

  burst_counter u_burst
  (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .bus(burst)
  );

  // Access sequencing state
  addr_t addr_q;
  addr_t addr_d;
  cycle_t cycle_q;
  cycle_t cycle_d;
  logic act_q;
  logic act_d;
  logic selected_q;
  logic selected_d;
  logic drive_q;
  logic drive_d;
  logic sleeping;
  logic proc_go;
  logic ctrl_seen;
  logic ctrl_go;
  logic desel;
  logic step;
  logic go_read;
  addr_t cur_addr;

  // Data path state
  logic [`DATA_W+`PAR_W-1:0] din_q;
  logic [`DATA_W+`PAR_W-1:0] din_d;
  logic [`DATA_W+`PAR_W-1:0] rd_q;
  logic [`DATA_W+`PAR_W-1:0] rd_d;
  logic wr_pend_q;
  logic wr_pend_d;
  addr_t wr_addr_q;
  addr_t wr_addr_d;

  // Strap and register state
  logic interleave_q;
  logic interleave_d;
  logic strap_taken_q;
  logic strap_taken_d;
  logic soft_sleep_q;
  logic soft_sleep_d;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdat_q;
  logic [31:0] rdat_d;

  assign cur_addr = {addr_q[`ADDR_W-1:2], burst.offset};

  always_comb
  begin
    // Pull-down on the pin is modelled by the pad; here low means awake
    sleeping = sleep_request_i | soft_sleep_q;
    proc_go = !sleeping && !processor_address_strobe_n_i && !primary_select_n_i;
    ctrl_seen = !sleeping && !controller_address_strobe_n_i && !proc_go;
    ctrl_go = ctrl_seen && !primary_select_n_i;
    desel = ctrl_seen && primary_select_n_i;
    step = !sleeping && !proc_go && !ctrl_seen && !burst_step_n_i && cycle_q != CYC_IDLE;
    go_read = proc_go || (ctrl_go && write_n_i);

    addr_d = addr_q;
    cycle_d = cycle_q;
    selected_d = selected_q;
    act_d = 1'b0;
    if (proc_go || ctrl_go)
    begin
      addr_d = address_i;
      act_d = 1'b1;
      selected_d = 1'b1;
      // Processor strobe always opens a read
      cycle_d = go_read ? CYC_READ : CYC_WRITE;
    end
    else if (desel)
    begin
      cycle_d = CYC_IDLE;
      selected_d = 1'b0;
    end
    else if (step)
    begin
      act_d = 1'b1;
    end

    burst.load = proc_go || ctrl_go;
    burst.step = step;
    burst.start = address_i[1:0];
    burst.interleave = interleave_q;

    // Stale data would show on the first clock after deselect, so mask it
    drive_d = !output_enable_n_i && !sleeping && !(go_read && !selected_q);
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      addr_q <= '0;
      cycle_q <= CYC_IDLE;
      act_q <= 1'b0;
      selected_q <= 1'b0;
      drive_q <= 1'b0;
    end
    else if (ce_i)
    begin
      addr_q <= addr_d;
      cycle_q <= cycle_d;
      act_q <= act_d;
      selected_q <= selected_d;
      drive_q <= drive_d;
    end
  end

  always_comb
  begin
    din_d = din_q;
    if (!drive_q)
    begin
      din_d = {byte_parity_io_i, data_i};
    end
    rd_d = rd_q;
    wr_pend_d = 1'b0;
    wr_addr_d = wr_addr_q;
    unique case (cycle_q)
      CYC_READ:
      begin
        if (act_q)
        begin
          rd_d = mem[cur_addr];
        end
      end
      CYC_WRITE:
      begin
        wr_pend_d = act_q;
        wr_addr_d = cur_addr;
      end
      CYC_IDLE:
      begin
        rd_d = rd_q;
      end
      default:
      begin
        rd_d = rd_q;
      end
    endcase
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      din_q <= '0;
      rd_q <= '0;
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
    end
    else if (ce_i)
    begin
      din_q <= din_d;
      rd_q <= rd_d;
      wr_pend_q <= wr_pend_d;
      wr_addr_q <= wr_addr_d;
    end
  end

  // Array has no reset so contents survive sleep and reset alike
  always_ff @(posedge clk_i)
  begin
    if (ce_i && wr_pend_q && !rst_i)
    begin
      mem[wr_addr_q] <= din_q;
    end
  end

  always_comb
  begin
    strap_taken_d = 1'b1;
    interleave_d = strap_taken_q ? interleave_q : burst_order_i;
    ack_d = wb_cyc_i && wb_stb_i && !ack_q;
    soft_sleep_d = soft_sleep_q;
    rdat_d = 32'h0000_0000;
    if (ack_d && wb_we_i && wb_sel_i[0] && wb_adr_i == `REG_CTRL)
    begin
      soft_sleep_d = wb_dat_i[`CTRL_SLEEP_BIT];
    end
    if (ack_d && !wb_we_i)
    begin
      unique case (wb_adr_i)
        `REG_CTRL:
        begin
          rdat_d[`CTRL_SLEEP_BIT] = soft_sleep_q;
        end
        `REG_STATUS:
        begin
          rdat_d[`ST_SLEEP_BIT] = sleeping;
          rdat_d[`ST_INTERLEAVE_BIT] = interleave_q;
          rdat_d[`ST_OFFSET_LO+1:`ST_OFFSET_LO] = burst.offset;
          rdat_d[`ST_DRIVE_BIT] = drive_q;
          rdat_d[`ST_SELECTED_BIT] = selected_q;
          rdat_d[`ST_READ_BIT] = cycle_q == CYC_READ;
        end
        `REG_ADDR:
        begin
          rdat_d[`ADDR_W-1:0] = addr_q;
        end
        default:
        begin
          rdat_d = 32'h0000_0000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      strap_taken_q <= 1'b0;
      interleave_q <= 1'b1;
      ack_q <= 1'b0;
      soft_sleep_q <= `CTRL_RESET;
      rdat_q <= 32'h0000_0000;
    end
    else if (ce_i)
    begin
      strap_taken_q <= strap_taken_d;
      interleave_q <= interleave_d;
      ack_q <= ack_d;
      soft_sleep_q <= soft_sleep_d;
      rdat_q <= rdat_d;
    end
  end

  assign data_o = rd_q[`DATA_W-1:0];
  assign byte_parity_io_o = rd_q[`DATA_W+`PAR_W-1:`DATA_W];
  assign data_oe_o = drive_q;
  assign byte_parity_io_oe_o = drive_q;
  assign wb_dat_o = rdat_q;
  assign wb_ack_o = ack_q;

endmodule

`default_nettype wire

/* tb/pipelined_sram_props.sv */
// Port assertions for the SRAM core.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ns
`default_nettype none
module pipelined_sram_props
(
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic controller_address_strobe_n_i,
  input wire logic processor_address_strobe_n_i,
  input wire logic primary_select_n_i,
  input wire logic burst_step_n_i,
  input wire logic sleep_request_i,
  input wire logic output_enable_n_i,
  input wire logic [31:0] data_o,
  input wire logic data_oe_o,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o
);
  wire logic ca = ce_i && !controller_address_strobe_n_i;
  wire logic pa = ce_i && !processor_address_strobe_n_i;
  wire logic sh = primary_select_n_i;
  wire logic zz = sleep_request_i;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence desel_s;
    ca && !pa && sh && !zz;
  endsequence
  sequence read_s;
    pa && !sh && !zz && !output_enable_n_i;
  endsequence
  a_wb_ack_next: assert property (ce_i && wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack missing");
  a_wb_ack_pulse: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
    else $error("ack held");
  a_wb_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
    else $error("read data outside ack");
  a_drive_off: assert property (ce_i && output_enable_n_i |=> !data_oe_o)
    else $error("pins driven with enable high");
  a_drive_on: assert property (ce_i && !output_enable_n_i && !ca && !pa && !zz |=> data_oe_o)
    else $error("pins not driven");
  a_first_read_mask: assert property (desel_s ##1 read_s |=> !data_oe_o)
    else $error("drive right after deselect");
  a_sleep_quiet: assert property (ce_i && zz |=> ##1 $stable(data_o))
    else $error("read taken in sleep");
  a_proc_ignored: assert property (pa && sh && !ca && burst_step_n_i |=> ##1 $stable(data_o))
    else $error("strobe taken without select");
endmodule
bind pipelined_sram pipelined_sram_props pipelined_sram_props_inst (.clk_i, .rst_i, .ce_i,
  .controller_address_strobe_n_i, .processor_address_strobe_n_i, .primary_select_n_i, .burst_step_n_i,
  .sleep_request_i, .output_enable_n_i, .data_o, .data_oe_o, .wb_cyc_i, .wb_stb_i, .wb_dat_o, .wb_ack_o);
`default_nettype wire

/* tb/sram_host_model.sv */
// Far-side model of the shared data and parity pins.
// Assumes the bench drives its side only while the core is released.
`timescale 1ns/1ns
`default_nettype none
module sram_host_model
(
  input wire logic clk_i,
  input wire logic core_oe_i,
  input wire logic [35:0] core_i,
  input wire logic host_oe_i,
  input wire logic [35:0] host_i,
  output logic [35:0] pins_o
);
  logic [35:0] last_q = 36'h0;
  always_comb
  begin
    if (core_oe_i)
      pins_o = core_i;
    else if (host_oe_i)
      pins_o = host_i;
    else
      pins_o = ~last_q; // Floating bus: show the inverse of the previous cycle's pins, so stale data returns every other cycle
  end
  always_ff @(posedge clk_i)
  begin
    last_q <= pins_o;
  end
endmodule
`default_nettype wire

/* tb/pipelined_sram_strobe_sleep_io_tb_top.sv */
// Self-checking bench for the pipelined SRAM core.
// Assumes the host model resolves the shared pins.
`timescale 1ns/1ns
`default_nettype none
module pipelined_sram_strobe_sleep_io_tb_top;
  import sram_pkg::*;
  localparam addr_t BASE = 19'h00a40;
  logic clk_i = 1'b0, rst_i = 1'b1, ca_n = 1'b1, pa_n = 1'b1, sel_n = 1'b0, st_n = 1'b1, wr_n = 1'b1;
  logic ord = 1'b0, slp = 1'b0, oe_n = 1'b1, host_oe = 1'b0, oe, poe, wb_ack_o;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  addr_t addr = '0;
  wb_adr_t wb_adr_i = '0;
  data_t d_o;
  par_t p_o;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic [35:0] host_d = 36'h0, pins;
  int mismatches = 0, cmp_count = 0, cycles = 0;
  logic [35:0] row_v[4] = '{36'h1_1111_1111, 36'h2_2222_2222, 36'h4_4444_4444, 36'h8_8888_8888};
  always #10 clk_i = ~clk_i;
  pipelined_sram pipelined_sram_inst (.clk_i, .rst_i, .ce_i(1'b1), .address_i(addr),
    .controller_address_strobe_n_i(ca_n), .processor_address_strobe_n_i(pa_n), .primary_select_n_i(sel_n),
    .burst_step_n_i(st_n), .write_n_i(wr_n), .burst_order_i(ord), .sleep_request_i(slp),
    .output_enable_n_i(oe_n), .data_i(pins[31:0]), .data_o(d_o), .data_oe_o(oe),
    .byte_parity_io_i(pins[35:32]), .byte_parity_io_o(p_o), .byte_parity_io_oe_o(poe), .wb_cyc_i,
    .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i(4'hf), .wb_dat_i, .wb_dat_o, .wb_ack_o);
  sram_host_model sram_host_model_inst (.clk_i, .core_oe_i(oe), .core_i({p_o, d_o}), .host_oe_i(host_oe),
    .host_i(host_d), .pins_o(pins));
  task automatic stop_test;
    $display("mismatches %0d comparisons %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string n, input logic [35:0] e, input logic [35:0] g);
    cmp_count++;
    if (g !== e)
    begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wb(input logic w, input wb_adr_t a, input logic [31:0] d);
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do
      @(posedge clk_i);
    while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic acc(input logic p, input logic c, input logic w, input addr_t a);
    pa_n <= !p;
    ca_n <= !c;
    wr_n <= !w;
    addr <= a;
    @(posedge clk_i);
    pa_n <= 1'b1;
    ca_n <= 1'b1;
    wr_n <= 1'b1;
  endtask
  task automatic wr(input addr_t a, input logic [35:0] v);
    oe_n <= 1'b1;
    acc(1'b0, 1'b1, 1'b1, a);
    host_d <= v;
    host_oe <= 1'b1;
    @(posedge clk_i);
    host_oe <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rdc(input logic p, input logic c, input logic w, input addr_t a, input logic [35:0] v);
    @(posedge clk_i);
    oe_n <= 1'b0;
    acc(p, c, w, a);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("read", v, {p_o, d_o});
  endtask
  task automatic burst(input logic p, input logic [1:0] s);
    @(posedge clk_i);
    oe_n <= 1'b0;
    acc(p, !p, 1'b0, BASE + s);
    st_n <= 1'b0;
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk_i);
      if (k == 2)
        st_n <= 1'b1;
      @(negedge clk_i);
      chk("burst", row_v[ord ? s ^ 2'(k) : s + 2'(k)], {p_o, d_o});
    end
  endtask
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 2000)
    begin
      mismatches++;
      stop_test();
    end
  end
  initial
  begin
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("reset", 36'h0, {oe, poe, wb_ack_o, d_o});
    wb(1'b0, 8'h00, 32'h0);
    chk("ctrl", 36'h0, rd);
    wb(1'b0, 8'h0c, 32'h0);
    chk("unmapped", 36'h0, rd);
    wb(1'b1, 8'h00, 32'h1);
    wb(1'b0, 8'h04, 32'h0);
    chk("status", 36'h1, rd[1:0]);
    wb(1'b1, 8'h00, 32'h0);
    for (int i = 0; i < 4; i++)
      wr(BASE + 19'(i), row_v[i]);
    for (int i = 0; i < 4; i++)
      rdc(1'b1, 1'b0, 1'b0, BASE + 19'(i), row_v[i]);
    rdc(1'b1, 1'b1, 1'b1, BASE, row_v[0]);
    @(posedge clk_i);
    sel_n <= 1'b1;
    acc(1'b1, 1'b0, 1'b0, 19'h7ffff);
    sel_n <= 1'b0;
    wb(1'b0, 8'h08, 32'h0);
    chk("address", 36'(BASE), rd);
    // No strobes while asleep: the far side keeps quiet, contents must hold
    slp <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("sleep hold", row_v[0], {p_o, d_o});
    wb(1'b0, 8'h04, 32'h0);
    chk("sleeping", 36'h1, rd[0]);
    slp <= 1'b0;
    ca_n <= 1'b0;
    sel_n <= 1'b1;
    @(posedge clk_i);
    sel_n <= 1'b0;
    acc(1'b1, 1'b0, 1'b0, BASE + 19'h3);
    @(negedge clk_i);
    chk("masked", 36'h0, oe);
    @(posedge clk_i);
    @(negedge clk_i);
    chk("drive", 36'h3, {oe, poe});
    chk("read", row_v[3], {p_o, d_o});
    @(posedge clk_i);
    oe_n <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk("released", 36'h0, {oe, poe});
    burst(1'b1, 2'd1);
    burst(1'b0, 2'd2);
    @(posedge clk_i);
    ord <= 1'b1;
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    burst(1'b0, 2'd1);
    burst(1'b1, 2'd3);
    stop_test();
  end
endmodule
`default_nettype wire
